// file: rtl/risc_ctrl.sv
// Reset, interrupt priority and stop control for an 8-bit core
`timescale 1ns/1ns
`include "risc_consts.svh"
module risc_ctrl
  import risc_pkg::*;
#(
  parameter bit EXT_LEVEL_SENSE = 1'b1
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // Reset sources
  input wire logic power_up_in,
  input wire logic reset_pin_n_in,
  // Interrupt sources
  input wire logic irq_n_in,
  input wire logic timer_count_is_one_in,
  input wire logic timer_step_in,
  // Core handshake
  input wire logic instr_end_in,
  input wire logic trap_fetched_in,
  input wire logic trap_return_in,
  input wire logic stop_exec_in,
  input wire logic wait_exec_in,
  input wire logic cli_in,
  input wire logic sei_in,
  // Timer control register write
  input wire logic timer_ctl_wr_in,
  input wire logic [7:0] timer_ctl_wdata_in,
  // Reset and vector outputs
  output logic core_reset_out,
  output logic abort_out,
  output logic irq_take_out,
  output logic fetch_next_out,
  output logic [12:0] vector_addr_out,
  output logic vector_valid_out,
  output logic stack_push_out,
  output logic stack_pop_out,
  output logic [12:0] sp_load_value_out,
  output logic sp_load_out,
  output logic ddr_clear_out,
  // Status
  output logic global_mask_out,
  output logic timer_irq_request_flag_out,
  output logic timer_irq_mask_flag_out,
  output logic [7:0] timer_control_register_out,
  output logic prescaler_clear_out,
  output logic stop_latch_out,
  output logic wait_latch_out,
  output logic osc_enable_out,
  output logic ext_pending_out
);
  risc_state_t st_q, st_d;
  logic gmask_q, gmask_d;
  logic treq_q, treq_d;
  logic tmask_q, tmask_d;
  logic [5:0] tlow_q, tlow_d;
  logic stop_q, stop_d;
  logic wait_q, wait_d;
  logic rst_q, rst_d;
  logic abort_q, abort_d;
  logic take_q, take_d;
  logic fetch_q, fetch_d;
  logic [12:0] vec_q, vec_d;
  logic vval_q, vval_d;
  logic push_q, push_d;
  logic pop_q, pop_d;
  logic spld_q, spld_d;
  logic ddrc_q, ddrc_d;
  logic pclr_q, pclr_d;
  logic osc_q, osc_d;
  risc_src_t src;
  logic por_done;
  logic por_start;
  logic ext_pend;
  logic ext_clear;
  logic ext_taken;
  logic in_reset;
  logic timer_ask;

  assign por_start = power_up_in;
  assign in_reset = (st_d == RISC_ST_POR) || (st_d == RISC_ST_RESET);

  risc_por_timer u_por (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in),
    .por_start_in(por_start),
    .por_done_out(por_done)
  );

  risc_ext_irq #(
    .LEVEL_SENSE(EXT_LEVEL_SENSE)
  ) u_ext (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in),
    .irq_n_in(irq_n_in),
    .clear_in(ext_clear),
    .taken_in(ext_taken),
    .pending_out(ext_pend)
  );

  // Priority pick at an instruction boundary
  always_comb begin
    timer_ask = treq_q & ~tmask_q;
    src = RISC_SRC_NONE;
    if (in_reset) begin
      src = RISC_SRC_RESET;
    end else if (instr_end_in && !gmask_q && ext_pend) begin
      src = RISC_SRC_EXT;
    end else if (instr_end_in && !gmask_q && timer_ask) begin
      src = RISC_SRC_TIMER;
    end else if (trap_fetched_in) begin
      src = RISC_SRC_TRAP;
    end
    ext_clear = in_reset;
    ext_taken = (src == RISC_SRC_EXT) && !EXT_LEVEL_SENSE;
    if (src == RISC_SRC_EXT && EXT_LEVEL_SENSE) begin
      ext_taken = 1'b1;
    end
  end

  always_comb begin
    st_d = st_q;
    case (st_q)
      RISC_ST_POR: begin
        if (por_done && reset_pin_n_in) begin
          st_d = RISC_ST_RUN;
        end
      end
      RISC_ST_RESET: begin
        if (reset_pin_n_in) begin
          st_d = RISC_ST_RUN;
        end
      end
      RISC_ST_RUN: begin
        if (stop_exec_in) begin
          st_d = RISC_ST_STOP;
        end
      end
      RISC_ST_STOP: begin
        // Oscillator restarts on an external request or reset
        if (!irq_n_in) begin
          st_d = RISC_ST_RUN;
        end
      end
      default: st_d = RISC_ST_RESET;
    endcase
    // Pin sampled each cycle, one low cycle suffices
    if (!reset_pin_n_in && st_q != RISC_ST_POR) begin
      st_d = RISC_ST_RESET;
    end
    if (power_up_in) begin
      st_d = RISC_ST_POR;
    end
  end

  always_comb begin
    gmask_d = gmask_q;
    treq_d = treq_q;
    tmask_d = tmask_q;
    tlow_d = tlow_q;
    stop_d = stop_q;
    wait_d = wait_q;
    if (timer_ctl_wr_in) begin
      treq_d = timer_ctl_wdata_in[`RISC_TCTL_REQ_BIT];
      tmask_d = timer_ctl_wdata_in[`RISC_TCTL_MASK_BIT];
      tlow_d = timer_ctl_wdata_in[5:0];
    end
    if (timer_step_in && timer_count_is_one_in && st_q != RISC_ST_STOP) begin
      treq_d = 1'b1;
    end
    if (cli_in) begin
      gmask_d = 1'b0;
    end
    if (sei_in) begin
      gmask_d = 1'b1;
    end
    if (trap_return_in) begin
      gmask_d = 1'b0;
    end
    if (wait_exec_in) begin
      wait_d = 1'b1;
      gmask_d = 1'b0;
    end
    if (src == RISC_SRC_EXT || src == RISC_SRC_TIMER || src == RISC_SRC_TRAP) begin
      gmask_d = 1'b1;
      wait_d = 1'b0;
    end
    if (st_q == RISC_ST_RUN && st_d == RISC_ST_STOP) begin
      treq_d = 1'b0;
      tmask_d = 1'b1;
      gmask_d = 1'b0;
      stop_d = 1'b1;
    end
    if (st_q == RISC_ST_STOP && st_d == RISC_ST_RUN) begin
      stop_d = 1'b0;
    end
    if (in_reset) begin
      treq_d = 1'b0;
      tmask_d = 1'b1;
      gmask_d = 1'b1;
      stop_d = 1'b0;
      wait_d = 1'b0;
      // Low timer bits kept across reset
      tlow_d = tlow_q;
    end
  end

  // Pulses towards the core
  always_comb begin
    rst_d = in_reset;
    abort_d = in_reset && !rst_q;
    take_d = (src == RISC_SRC_EXT) || (src == RISC_SRC_TIMER) || (src == RISC_SRC_TRAP);
    fetch_d = instr_end_in && !in_reset && !take_d;
    push_d = take_d;
    pop_d = trap_return_in && !in_reset;
    spld_d = in_reset;
    ddrc_d = in_reset;
    pclr_d = (st_q == RISC_ST_RUN && st_d == RISC_ST_STOP) ||
             (timer_ctl_wr_in && timer_ctl_wdata_in[`RISC_TCTL_PRESC_CLR_BIT]);
    osc_d = !stop_d;
    vval_d = 1'b1;
    case (src)
      RISC_SRC_RESET: vec_d = `RISC_VEC_RESET;
      RISC_SRC_EXT: vec_d = `RISC_VEC_EXT;
      RISC_SRC_TIMER: vec_d = wait_q ? `RISC_VEC_TIMER_WAIT : `RISC_VEC_TIMER;
      RISC_SRC_TRAP: vec_d = `RISC_VEC_TRAP;
      default: begin
        vec_d = vec_q;
        vval_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      st_q <= RISC_ST_POR;
      gmask_q <= 1'b1;
      treq_q <= 1'b0;
      tmask_q <= 1'b1;
      tlow_q <= 6'h00;
      stop_q <= 1'b0;
      wait_q <= 1'b0;
      rst_q <= 1'b1;
      abort_q <= 1'b0;
      take_q <= 1'b0;
      fetch_q <= 1'b0;
      vec_q <= `RISC_VEC_RESET;
      vval_q <= 1'b0;
      push_q <= 1'b0;
      pop_q <= 1'b0;
      spld_q <= 1'b1;
      ddrc_q <= 1'b1;
      pclr_q <= 1'b0;
      osc_q <= 1'b1;
    end else if (clk_en_in) begin
      st_q <= st_d;
      gmask_q <= gmask_d;
      treq_q <= treq_d;
      tmask_q <= tmask_d;
      tlow_q <= tlow_d;
      stop_q <= stop_d;
      wait_q <= wait_d;
      rst_q <= rst_d;
      abort_q <= abort_d;
      take_q <= take_d;
      fetch_q <= fetch_d;
      vec_q <= vec_d;
      vval_q <= vval_d;
      push_q <= push_d;
      pop_q <= pop_d;
      spld_q <= spld_d;
      ddrc_q <= ddrc_d;
      pclr_q <= pclr_d;
      osc_q <= osc_d;
    end
  end

  // Stopped oscillator modelled as enable low
  assign core_reset_out = rst_q;
  assign abort_out = abort_q;
  assign irq_take_out = take_q;
  assign fetch_next_out = fetch_q;
  assign vector_addr_out = vec_q;
  assign vector_valid_out = vval_q;
  assign stack_push_out = push_q;
  assign stack_pop_out = pop_q;
  assign sp_load_value_out = `RISC_SP_RESET;
  assign sp_load_out = spld_q;
  assign ddr_clear_out = ddrc_q;
  assign global_mask_out = gmask_q;
  assign timer_irq_request_flag_out = treq_q;
  assign timer_irq_mask_flag_out = tmask_q;
  assign timer_control_register_out = {treq_q, tmask_q, tlow_q[5:4], 1'b0, tlow_q[2:0]};
  assign prescaler_clear_out = pclr_q;
  assign stop_latch_out = stop_q;
  assign wait_latch_out = wait_q;
  assign osc_enable_out = osc_q;
  assign ext_pending_out = ext_pend;
endmodule

// file: rtl/risc_consts.svh
// Constants for the reset, interrupt and stop control block
`ifndef RISC_CONSTS_SVH
`define RISC_CONSTS_SVH

`define RISC_CLK_MHZ 25
`define RISC_POR_CYCLES 1920
`define RISC_SP_RESET 13'h007f
`define RISC_VEC_RESET 13'h1ffe
`define RISC_VEC_TRAP 13'h1ffc
`define RISC_VEC_EXT 13'h1ffa
`define RISC_VEC_TIMER 13'h1ff8
`define RISC_VEC_TIMER_WAIT 13'h1ff6
`define RISC_TCTL_REQ_BIT 7
`define RISC_TCTL_MASK_BIT 6
`define RISC_TCTL_PRESC_CLR_BIT 3
`define RISC_DDR_WIDTH 32

`endif

// file: rtl/risc_pkg.sv
// Types for the reset, interrupt and stop control block
package risc_pkg;
  typedef enum logic [2:0] {
    RISC_SRC_NONE = 3'h0,
    RISC_SRC_RESET = 3'h1,
    RISC_SRC_EXT = 3'h2,
    RISC_SRC_TIMER = 3'h3,
    RISC_SRC_TRAP = 3'h4
  } risc_src_t;

  typedef enum logic [1:0] {
    RISC_ST_POR = 2'h0,
    RISC_ST_RESET = 2'h1,
    RISC_ST_RUN = 2'h2,
    RISC_ST_STOP = 2'h3
  } risc_state_t;
endpackage

// file: rtl/risc_por_timer.sv
// Power-on delay counter holding the core in reset
`timescale 1ns/1ns
`include "risc_consts.svh"
module risc_por_timer (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // Control
  input wire logic por_start_in,
  // Status
  output logic por_done_out
);
  logic [10:0] cnt_q, cnt_d;
  logic done_q, done_d;

  always_comb begin
    cnt_d = cnt_q;
    done_d = done_q;
    if (por_start_in) begin
      cnt_d = 11'h000;
      done_d = 1'b0;
    end else if (!done_q) begin
      if (cnt_q == 11'(`RISC_POR_CYCLES - 1)) begin
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 11'h001;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cnt_q <= 11'h000;
      done_q <= 1'b0;
    end else if (clk_en_in) begin
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign por_done_out = done_q;
endmodule

// file: rtl/risc_ext_irq.sv
// External request latch with level-plus-edge or edge-only detection
`timescale 1ns/1ns
module risc_ext_irq #(
  parameter bit LEVEL_SENSE = 1'b1
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // Control
  input wire logic irq_n_in,
  input wire logic clear_in,
  input wire logic taken_in,
  // Status
  output logic pending_out
);
  logic prev_q, prev_d;
  logic pend_q, pend_d;
  logic fall;

  always_comb begin
    fall = prev_q & ~irq_n_in;
    prev_d = irq_n_in;
    pend_d = pend_q;
    if (clear_in || taken_in) begin
      pend_d = 1'b0;
    end
    // Set wins over the clear so no edge is lost
    if (fall) begin
      pend_d = 1'b1;
    end
    // Held-low line asks again after service
    if (LEVEL_SENSE && !irq_n_in && !clear_in) begin
      pend_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      prev_q <= 1'b1;
      pend_q <= 1'b0;
    end else if (clk_en_in) begin
      prev_q <= prev_d;
      pend_q <= pend_d;
    end
  end

  assign pending_out = pend_q;
endmodule

// file: dv/risc_src_model.sv
// Reset pin and external request source facing the control block
`timescale 1ns/1ns
module risc_src_model #(
  parameter int GAP = 20
) (
  // Clock
  input wire logic core_clk_in,
  // Commands from the bench
  input wire logic rst_go_in,
  input wire logic irq_go_in,
  input wire logic irq_hold_in,
  // Pins
  output logic reset_pin_n_out = 1'b1,
  output logic irq_n_out = 1'b1
);
  int gap_q = 0;
  logic fire;
  assign fire = irq_go_in && gap_q == 0;
  always @(posedge core_clk_in) begin
    reset_pin_n_out <= !rst_go_in;
    // Held request stands for a wire-ORed source still asking
    irq_n_out <= !(fire || irq_hold_in);
    // Too-early requests are dropped, as a real source must not send them
    gap_q <= fire ? GAP : (gap_q > 0 ? gap_q - 1 : 0);
  end
endmodule

// file: dv/risc_ctrl_properties.sv
// Concurrent checks on the control block ports
`timescale 1ns/1ns
module risc_ctrl_properties (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Inputs
  input wire logic power_up_in,
  input wire logic reset_pin_n_in,
  input wire logic instr_end_in,
  input wire logic trap_fetched_in,
  input wire logic trap_return_in,
  input wire logic cli_in,
  input wire logic stop_exec_in,
  input wire logic timer_count_is_one_in,
  input wire logic timer_step_in,
  // Outputs
  input wire logic core_reset_out,
  input wire logic abort_out,
  input wire logic irq_take_out,
  input wire logic [12:0] vector_addr_out,
  input wire logic [12:0] sp_load_value_out,
  input wire logic ddr_clear_out,
  input wire logic global_mask_out,
  input wire logic timer_irq_request_flag_out,
  input wire logic timer_irq_mask_flag_out,
  input wire logic [7:0] timer_control_register_out,
  input wire logic stop_latch_out,
  input wire logic ext_pending_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [11:0] por_q;
  logic [11:0] por_d;
  logic run;
  assign run = !core_reset_out && reset_pin_n_in && !power_up_in;
  // Saturating count of cycles since the last supply rise
  always_comb begin
    por_d = por_q;
    if (!rst_n_in || power_up_in) por_d = 12'h000;
    else if (por_q != 12'hfff) por_d = por_q + 12'h001;
  end
  always_ff @(posedge core_clk_in) begin
    por_q <= por_d;
  end
  sequence s_take(logic [12:0] v);
    irq_take_out && vector_addr_out == v && global_mask_out;
  endsequence
  a_por_length: assert property ($fell(core_reset_out) |-> por_q >= 12'd1919)
    else $error("reset left before the power-on delay");
  a_reset_entry: assert property ($rose(core_reset_out) |-> abort_out && global_mask_out
    && timer_irq_mask_flag_out && !timer_irq_request_flag_out)
    else $error("reset entry side effects wrong");
  a_reset_vector: assert property (core_reset_out |-> vector_addr_out == 13'h1ffe
    && sp_load_value_out == 13'h007f && ddr_clear_out)
    else $error("reset vector, stack or direction clear wrong");
  a_ext_first: assert property (instr_end_in && run && ext_pending_out && !global_mask_out
    |=> s_take(13'h1ffa)) else $error("external request not taken first");
  a_masked_wait: assert property (instr_end_in && global_mask_out && !cli_in && !trap_return_in
    && !trap_fetched_in |=> !irq_take_out) else $error("interrupt taken while masked");
  a_trap_any: assert property (trap_fetched_in && run && global_mask_out |=> s_take(13'h1ffc))
    else $error("software trap not taken under mask");
  a_timer_raise: assert property (timer_step_in && timer_count_is_one_in && run
    && !timer_irq_mask_flag_out && !stop_exec_in |=> timer_irq_request_flag_out)
    else $error("timer request not raised");
  a_stop_entry: assert property (stop_exec_in && run |=> stop_latch_out && !global_mask_out
    && timer_irq_mask_flag_out && !timer_irq_request_flag_out) else $error("stop entry wrong");
  a_tctl_layout: assert property (timer_control_register_out[7:6] == {
    timer_irq_request_flag_out, timer_irq_mask_flag_out} && !timer_control_register_out[3])
    else $error("timer control layout wrong");
endmodule
bind risc_ctrl risc_ctrl_properties i_props (.*);

// file: dv/tb.sv
// Self-checking bench for the reset, interrupt and stop control block
`timescale 1ns/1ns
module tb;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic power_up_in = 1'b0;
  logic rst_go = 1'b0;
  logic irq_go = 1'b0;
  logic hold = 1'b0;
  logic [9:0] p = 10'h000;
  logic [7:0] wd = 8'h00;
  logic pin_n, irq_n, rs, tk, gm, tq, tm, sl, ep;
  logic fn, vv, sp, po, sld, dc, pc, wl, oe;
  logic [12:0] va;
  logic [7:0] tctl;
  logic [12:0] q[$];
  integer seed = 32'h818ad6d0;
  int errors = 0;
  int compares = 0;
  int n;
  initial begin
    forever #20 core_clk_in = ~core_clk_in;
  end
  risc_src_model i_src (.core_clk_in(core_clk_in), .rst_go_in(rst_go), .irq_go_in(irq_go),
    .irq_hold_in(hold),
    .reset_pin_n_out(pin_n), .irq_n_out(irq_n));
  risc_ctrl i_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1),
    .power_up_in(power_up_in), .reset_pin_n_in(pin_n), .irq_n_in(irq_n),
    .timer_count_is_one_in(p[9]), .timer_step_in(p[8]), .instr_end_in(p[0]),
    .trap_fetched_in(p[1]), .trap_return_in(p[2]), .stop_exec_in(p[3]), .wait_exec_in(p[4]),
    .cli_in(p[5]), .sei_in(p[6]), .timer_ctl_wr_in(p[7]), .timer_ctl_wdata_in(wd),
    .core_reset_out(rs), .abort_out(), .irq_take_out(tk), .fetch_next_out(fn),
    .vector_addr_out(va), .vector_valid_out(vv), .stack_push_out(sp), .stack_pop_out(po),
    .sp_load_value_out(), .sp_load_out(sld), .ddr_clear_out(dc), .global_mask_out(gm),
    .timer_irq_request_flag_out(tq), .timer_irq_mask_flag_out(tm),
    .timer_control_register_out(tctl), .prescaler_clear_out(pc), .stop_latch_out(sl),
    .wait_latch_out(wl), .osc_enable_out(oe), .ext_pending_out(ep));
  task end_sim;
    if (errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task chk_vec(input logic [12:0] g, input logic [12:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task chk_bit(input logic g, input logic e);
    chk_vec({12'h000, g}, {12'h000, e});
  endtask
  // One-cycle strobe; outputs are settled when it returns
  task pulse(input logic [9:0] v);
    @(posedge core_clk_in) p <= v;
    @(posedge core_clk_in) p <= 10'h000;
    #1;
  endtask
  task tmr(input logic wt);
    q.push_back(wt ? 13'h1ff6 : 13'h1ff8);
    pulse(10'h300);
  endtask
  // Wait leaves room for the source's minimum spacing
  task ext_req;
    q.push_back(13'h1ffa);
    @(posedge core_clk_in) irq_go <= 1'b1;
    @(posedge core_clk_in) irq_go <= 1'b0;
    repeat (24) @(posedge core_clk_in);
    #1;
  endtask
  task take;
    pulse(10'h001);
    chk_bit(tk, 1'b1);
    chk_vec(va, q.pop_front());
    chk_bit(gm, 1'b1);
    chk_bit(vv & sp & !fn, 1'b1);
    pulse(10'h004);
    chk_bit(po, 1'b1);
  endtask
  initial begin
    repeat (2) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    @(posedge core_clk_in) power_up_in <= 1'b1;
    @(posedge core_clk_in) power_up_in <= 1'b0;
    n = 0;
    #1;
    while (rs !== 1'b0 && n < 3000) begin
      @(posedge core_clk_in);
      #1;
      n++;
    end
    if (n >= 3000) begin
      errors++;
      end_sim;
    end
    chk_bit(n >= 1919 && n <= 1923, 1'b1);
    chk_bit(gm & tm, 1'b1);
    chk_bit(tq, 1'b0);
    repeat (4) begin
      @(posedge core_clk_in) wd <= 8'($random(seed)) & 8'h3f;
      pulse(10'h080);
      chk_vec({5'h00, tctl}, {5'h00, wd & 8'hf7});
    end
    ext_req;
    tmr(1'b0);
    chk_bit(tq, 1'b1);
    pulse(10'h001);
    chk_bit(tk, 1'b0);
    chk_bit(ep, 1'b1);
    chk_bit(fn, 1'b1);
    pulse(10'h002);
    chk_vec(va, 13'h1ffc);
    pulse(10'h004);
    take;
    take;
    chk_bit(tq, 1'b1);
    @(posedge core_clk_in) wd <= 8'h00;
    pulse(10'h080);
    pulse(10'h010);
    chk_bit(wl & !gm, 1'b1);
    tmr(1'b1);
    take;
    pulse(10'h080);
    pulse(10'h040);
    pulse(10'h300);
    pulse(10'h008);
    chk_bit(sl & tm & !tq & !gm, 1'b1);
    chk_bit(pc & !oe, 1'b1);
    ext_req;
    chk_bit(sl, 1'b0);
    chk_bit(oe, 1'b1);
    take;
    // Line held low through service must ask again
    @(posedge core_clk_in) hold <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    q.push_back(13'h1ffa);
    take;
    chk_bit(ep, 1'b1);
    @(posedge core_clk_in) hold <= 1'b0;
    pulse(10'h040);
    ext_req;
    pulse(10'h010);
    q.delete();
    @(posedge core_clk_in) rst_go <= 1'b1;
    @(posedge core_clk_in) rst_go <= 1'b0;
    @(posedge core_clk_in);
    #1;
    chk_bit(rs, 1'b1);
    chk_vec(va, 13'h1ffe);
    chk_bit(sld & dc, 1'b1);
    repeat (4) @(posedge core_clk_in);
    #1;
    chk_bit(rs | ep | sl | wl, 1'b0);
    chk_bit(gm & tm, 1'b1);
    end_sim;
  end
endmodule
